// ### verilog/boost_cfg_pkg.sv
// Shared constants and carriers for the boost and dimming configuration byte
package boost_cfg_pkg;

  // ==========================================================================
  // Register map (printed offsets are indices, byte address is four times)
  localparam logic [9:0]  CFG_INDEX      = 10'h0a2;
  localparam logic [9:0]  STATUS_INDEX   = 10'h0b0;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  // ==========================================================================
  // Field positions of the configuration byte
  localparam int          BIT_FAST_ADAPT = 7;
  localparam int          BIT_SLOW_RATE  = 6;
  localparam int          BIT_SMOOTH     = 5;
  localparam int          BIT_MODE_25    = 4;
  localparam int          BIT_ADAPT_EN   = 3;
  localparam int          BIT_BOOST_EN   = 2;
  localparam int          BIT_ILIM_SEL   = 1;
  localparam int          BIT_ISLOPE_HI  = 0;

  // ==========================================================================
  // Adaptive update rate
  localparam logic [3:0]  SLOW_DIVIDE_LAST = 4'hf;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RAMP,
    ST_ADAPT,
    ST_FIXED
  } boost_state_t;

  typedef struct packed {
    logic fast_adapt;
    logic slow_rate;
    logic smooth_ramp_en;
    logic mode_25;
    logic adapt_en;
    logic boost_en;
    logic inductor_limit_sel;
    logic current_slope_hi;
  } cfg_t;

endpackage : boost_cfg_pkg

// ### verilog/cfg_byte_store.sv
// Configuration byte holder loaded from non-volatile storage after reset
`timescale 1ns/100ps
module cfg_byte_store (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic [7:0]        i_nv_byte,
  input  wire logic              i_wr_en,
  input  wire logic [7:0]        i_wr_data,
  output boost_cfg_pkg::cfg_t    o_cfg,
  output logic                   o_loaded
);
  import boost_cfg_pkg::*;

  logic [7:0] byte_reg;
  logic       loaded_reg;

  // ==========================================================================
  // Load once after reset release, then bus writes
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      byte_reg   <= CFG_RESET;
      loaded_reg <= 1'b0;
    end else if (!loaded_reg) begin
      byte_reg   <= i_nv_byte;
      loaded_reg <= 1'b1;
    end else if (i_wr_en) begin
      byte_reg   <= i_wr_data;
    end
  end

  assign o_cfg    = cfg_t'(byte_reg);
  assign o_loaded = loaded_reg;

endmodule : cfg_byte_store

// ### verilog/boost_adaptive_config.sv
// Boost and dimming configuration byte with AXI4-Lite access and boost control
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
module boost_adaptive_config #(
  parameter int VSET_W = 5,
  parameter int HEAD_W = 3
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic [11:0]       i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [11:0]       i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  input  wire logic [7:0]        i_nv_byte,
  input  wire logic              i_backlight_en,
  input  wire logic              i_pwm_cycle_tick,
  input  wire logic              i_startup_reached,
  input  wire logic [VSET_W-1:0] i_startup_voltage_setting,
  input  wire logic [HEAD_W-1:0] i_sink_headroom_setting,
  output logic                   o_boost_on,
  output logic                   o_adapt_active,
  output logic                   o_adapt_step,
  output logic                   o_fast_adapt,
  output logic [VSET_W-1:0]      o_vout_setting,
  output logic [HEAD_W-1:0]      o_headroom,
  output logic                   o_smooth_ramp_en,
  output logic                   o_mode_25,
  output logic                   o_inductor_limit_sel,
  output logic                   o_current_slope_hi
);
  import boost_cfg_pkg::*;

  function automatic logic [9:0] word_index(input logic [11:0] addr);
    word_index = addr[11:2];
  endfunction : word_index

  cfg_t          cfg;
  logic          loaded;
  logic          aw_hold_reg;
  logic          w_hold_reg;
  logic [9:0]    aw_index_reg;
  logic [31:0]   wdata_reg;
  logic          wstrb0_reg;
  logic          bvalid_reg;
  logic [1:0]    bresp_reg;
  logic          rvalid_reg;
  logic [1:0]    rresp_reg;
  logic [31:0]   rdata_reg;
  logic          aw_hs;
  logic          w_hs;
  logic          aw_have;
  logic          w_have;
  logic          do_write;
  logic [9:0]    wr_index;
  logic [31:0]   wr_data;
  logic          wr_strb0;
  logic          cfg_wr;
  logic          ar_hs;
  boost_state_t  state_reg;
  boost_state_t  state_next;
  logic          run_req;
  logic [3:0]    div_reg;
  logic          step_reg;
  logic [VSET_W-1:0] vout_reg;
  logic [HEAD_W-1:0] head_reg;

  // ==========================================================================
  // Configuration storage
  cfg_byte_store u_store (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_nv_byte (i_nv_byte),
    .i_wr_en   (cfg_wr),
    .i_wr_data (wr_data[7:0]),
    .o_cfg     (cfg),
    .o_loaded  (loaded)
  );

  // ==========================================================================
  // AXI4-Lite write channel
  assign o_s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign o_s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign aw_hs    = i_s_axi_awvalid && o_s_axi_awready;
  assign w_hs     = i_s_axi_wvalid && o_s_axi_wready;
  assign aw_have  = aw_hold_reg || aw_hs;
  assign w_have   = w_hold_reg || w_hs;
  assign do_write = aw_have && w_have && !bvalid_reg;
  assign wr_index = aw_hold_reg ? aw_index_reg
                                : word_index(i_s_axi_awaddr);
  assign wr_data  = w_hold_reg ? wdata_reg : i_s_axi_wdata;
  assign wr_strb0 = w_hold_reg ? wstrb0_reg : i_s_axi_wstrb[0];
  assign cfg_wr   = do_write && loaded && wr_index == CFG_INDEX && wr_strb0;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      aw_index_reg <= '0;
      wdata_reg    <= '0;
      wstrb0_reg   <= 1'b0;
    end else begin
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
      end else begin
        if (aw_hs) begin
          aw_hold_reg  <= 1'b1;
          aw_index_reg <= word_index(i_s_axi_awaddr);
        end
        if (w_hs) begin
          w_hold_reg <= 1'b1;
          wdata_reg  <= i_s_axi_wdata;
          wstrb0_reg <= i_s_axi_wstrb[0];
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_index == CFG_INDEX || wr_index == STATUS_INDEX)
                    ? RESP_OKAY : RESP_DECERR;
    end else if (i_s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp  = bresp_reg;

  // ==========================================================================
  // AXI4-Lite read channel
  assign o_s_axi_arready = !rvalid_reg;
  assign ar_hs           = i_s_axi_arvalid && o_s_axi_arready;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      unique case (word_index(i_s_axi_araddr))
        CFG_INDEX:    rdata_reg <= {24'h000000, cfg};
        STATUS_INDEX: rdata_reg <= {24'h000000, div_reg, 1'b0,
                                    loaded, state_reg};
        default: begin
          rdata_reg <= '0;
          rresp_reg <= RESP_DECERR;
        end
      endcase
    end else if (i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rresp  = rresp_reg;
  assign o_s_axi_rdata  = rdata_reg;

  // ==========================================================================
  // Boost sequencing
  assign run_req = cfg.boost_en && i_backlight_en && loaded;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF:   if (run_req) state_next = cfg.adapt_en ? ST_RAMP : ST_FIXED;
      ST_RAMP:  if (!cfg.adapt_en) state_next = ST_FIXED;
                else if (i_startup_reached) state_next = ST_ADAPT;
      ST_ADAPT: if (!cfg.adapt_en) state_next = ST_FIXED;
      ST_FIXED: if (cfg.adapt_en) state_next = ST_RAMP;
    endcase
    if (!run_req) state_next = ST_OFF;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) state_reg <= ST_OFF;
    else state_reg <= state_next;
  end

  // Adaptive readjust divider
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg  <= '0;
      step_reg <= 1'b0;
    end else begin
      step_reg <= 1'b0;
      if (state_reg != ST_ADAPT) begin
        div_reg <= '0;
      end else if (i_pwm_cycle_tick) begin
        div_reg  <= div_reg + 4'h1;
        step_reg <= !cfg.slow_rate || div_reg == SLOW_DIVIDE_LAST;
      end
    end
  end

  // Voltage and headroom targets
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      vout_reg <= '0;
      head_reg <= '0;
    end else begin
      if (state_reg != ST_ADAPT)
        vout_reg <= i_startup_voltage_setting;
      head_reg <= i_sink_headroom_setting;
    end
  end

  assign o_boost_on           = state_reg != ST_OFF;
  assign o_adapt_active       = state_reg == ST_ADAPT;
  assign o_adapt_step         = step_reg;
  assign o_vout_setting       = vout_reg;
  assign o_headroom           = head_reg;
  assign o_fast_adapt         = cfg.fast_adapt;
  assign o_smooth_ramp_en     = cfg.smooth_ramp_en;
  assign o_mode_25            = cfg.mode_25;
  assign o_inductor_limit_sel = cfg.inductor_limit_sel;
  assign o_current_slope_hi   = cfg.current_slope_hi;

  // ==========================================================================
  // Checks
  sequence s_ramp_done;
    state_reg == ST_RAMP && i_startup_reached && cfg.adapt_en && run_req;
  endsequence

  a_fast_adapt_bit: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) o_fast_adapt == cfg[BIT_FAST_ADAPT])
    else $error("fast adapt not from bit 7");

  a_slow_rate_step: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    o_adapt_step && $past(cfg.slow_rate)
    |-> $past(div_reg) == SLOW_DIVIDE_LAST)
    else $error("slow rate stepped early");

  a_normal_rate_step: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    state_reg == ST_ADAPT && state_next == ST_ADAPT && i_pwm_cycle_tick
    && !cfg.slow_rate |=> o_adapt_step)
    else $error("normal rate missed a step");

  a_smooth_bit: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) o_smooth_ramp_en == cfg[BIT_SMOOTH])
    else $error("smoothing not from bit 5");

  a_mode_split: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) o_mode_25 == cfg[BIT_MODE_25])
    else $error("dimming split not from bit 4");

  a_fixed_no_adapt: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    run_req && !cfg.adapt_en |=> !o_adapt_active ##0 o_boost_on)
    else $error("adapted while disabled");

  a_ramp_then_track: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) s_ramp_done |=> o_adapt_active)
    else $error("no tracking after start-up voltage");

  a_headroom_copy: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    o_adapt_active |-> o_headroom == $past(i_sink_headroom_setting))
    else $error("headroom not from stored setting");

  a_boost_gate: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) !run_req |=> !o_boost_on)
    else $error("boost on while gated");

  a_limit_bit: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) o_inductor_limit_sel == cfg[BIT_ILIM_SEL])
    else $error("inductor limit not from bit 1");

  a_cfg_readback: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    ar_hs && word_index(i_s_axi_araddr) == CFG_INDEX
    |=> o_s_axi_rvalid && o_s_axi_rdata[7:0] == $past(cfg))
    else $error("read differs from stored byte");

endmodule : boost_adaptive_config

// ### tb/tb_top.sv
// Self-checking bench for the boost and dimming configuration block
`timescale 1ns/100ps
module tb_top;
  import boost_cfg_pkg::*;

  localparam logic [11:0] CFG_ADDR  = {CFG_INDEX, 2'b00};
  localparam logic [11:0] STAT_ADDR = {STATUS_INDEX, 2'b00};

  // ==========================================================================
  // Signals
  logic        clk_sys;
  logic        resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, tick = 1'b0, reached = 1'b0;
  logic        backlight_en = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [7:0]  nv_byte = 8'h93;
  logic [4:0]  vset = 5'h13;
  logic [2:0]  head = 3'h5;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        boost_on, adapt_active, adapt_step, fast_adapt;
  logic        smooth, mode_25, ilim, islope;
  logic [4:0]  vout;
  logic [2:0]  headroom;
  int          fails = 0, checks_done = 0, steps = 0;

  boost_adaptive_config uut (
    .i_clk_sys                 (clk_sys),
    .i_resetn                  (resetn),
    .i_s_axi_awaddr            (awaddr),
    .i_s_axi_awvalid           (awvalid),
    .o_s_axi_awready           (awready),
    .i_s_axi_wdata             (wdata),
    .i_s_axi_wstrb             (wstrb),
    .i_s_axi_wvalid            (wvalid),
    .o_s_axi_wready            (wready),
    .o_s_axi_bresp             (bresp),
    .o_s_axi_bvalid            (bvalid),
    .i_s_axi_bready            (bready),
    .i_s_axi_araddr            (araddr),
    .i_s_axi_arvalid           (arvalid),
    .o_s_axi_arready           (arready),
    .o_s_axi_rdata             (rdata),
    .o_s_axi_rresp             (rresp),
    .o_s_axi_rvalid            (rvalid),
    .i_s_axi_rready            (rready),
    .i_nv_byte                 (nv_byte),
    .i_backlight_en            (backlight_en),
    .i_pwm_cycle_tick          (tick),
    .i_startup_reached         (reached),
    .i_startup_voltage_setting (vset),
    .i_sink_headroom_setting   (head),
    .o_boost_on                (boost_on),
    .o_adapt_active            (adapt_active),
    .o_adapt_step              (adapt_step),
    .o_fast_adapt              (fast_adapt),
    .o_vout_setting            (vout),
    .o_headroom                (headroom),
    .o_smooth_ramp_en          (smooth),
    .o_mode_25                 (mode_25),
    .o_inductor_limit_sel      (ilim),
    .o_current_slope_hi        (islope)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (adapt_step === 1'b1) steps <= steps + 1;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic too_long(input int n);
    if (n >= 40) begin
      fails++;
      give_verdict();
    end
  endtask : too_long

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    too_long(n);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    too_long(n);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_read

  // Write the byte, read it back, compare the decoded field outputs
  task automatic wr_cfg(input logic [7:0] b);
    logic [1:0]  r;
    logic [31:0] d;
    logic [4:0]  f;
    axi_write(CFG_ADDR, {24'h0, b}, r);
    check(r, RESP_OKAY);
    axi_read(CFG_ADDR, d, r);
    check(d, {24'h0, b});
    check(r, RESP_OKAY);
    f = {fast_adapt, smooth, mode_25, ilim, islope};
    check(f, {b[7], b[5:4], b[1:0]});
  endtask : wr_cfg

  task automatic ticks(input int n, output int c);
    int base;
    base = steps;
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clk_sys);
      tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (2) @(posedge clk_sys);
    c = steps - base;
  endtask : ticks

  // ==========================================================================
  // Scenarios
  task automatic test_load_and_errors;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(CFG_ADDR, d, r);
    check(d, 32'h93);
    check({fast_adapt, smooth, mode_25, ilim, islope}, 5'h17);
    check(boost_on, 1'b0);
    axi_read(12'h004, d, r);
    check(d, 32'h0);
    check(r, RESP_DECERR);
    axi_write(12'h008, 32'hff, r);
    check(r, RESP_DECERR);
    axi_write(STAT_ADDR, 32'hff, r);
    check(r, RESP_OKAY);
    axi_read(STAT_ADDR, d, r);
    check(d, 32'h04);
    axi_read(CFG_ADDR, d, r);
    check(d, 32'h93);
    $display("load and bus error test done");
  endtask : test_load_and_errors

  task automatic test_adaptive;
    int c;
    wr_cfg(8'h2e);
    repeat (2) @(posedge clk_sys);
    check({boost_on, adapt_active}, 2'b10);
    check(vout, vset);
    reached <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({boost_on, adapt_active}, 2'b11);
    check(headroom, head);
    ticks(3, c);
    check(c, 3);
    $display("adaptive test done");
  endtask : test_adaptive

  task automatic test_fixed;
    int c;
    wr_cfg(8'h26);
    repeat (2) @(posedge clk_sys);
    check({boost_on, adapt_active}, 2'b10);
    check(vout, vset);
    ticks(2, c);
    check(c, 0);
    $display("fixed voltage test done");
  endtask : test_fixed

  task automatic test_slow_rate;
    int c;
    backlight_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(boost_on, 1'b0);
    wr_cfg(8'h6c);
    backlight_en <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(adapt_active, 1'b1);
    ticks(15, c);
    check(c, 0);
    ticks(1, c);
    check(c, 1);
    wr_cfg(8'h28);
    repeat (2) @(posedge clk_sys);
    check(boost_on, 1'b0);
    $display("slow rate test done");
  endtask : test_slow_rate

  // Reset in mid-run reloads the byte from the non-volatile image
  task automatic test_reload;
    logic [31:0] d;
    logic [1:0]  r;
    nv_byte <= 8'h5a;
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(boost_on, 1'b0);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    axi_read(CFG_ADDR, d, r);
    check(d, 32'h5a);
    check({fast_adapt, smooth, mode_25, ilim, islope}, 5'h06);
    check(boost_on, 1'b0);
    $display("reload test done");
  endtask : test_reload

  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    test_load_and_errors();
    test_adaptive();
    test_fixed();
    test_slow_rate();
    test_reload();
    give_verdict();
  end

endmodule : tb_top
